// >>> global_ctl_pkg.sv
// package: register map, field positions, reset values and timing for global control 4..6
package global_ctl_pkg;
  // printed offsets are not multiples of four: they are register indices
  localparam logic [7:0]  idx_mirror_mode     = 8'h05;
  localparam logic [7:0]  idx_uplink          = 8'h06;
  localparam logic [7:0]  idx_storm_low       = 8'h07;
  localparam logic [7:0]  idx_flush_freeze    = 8'h08;
  localparam logic [9:0]  addr_mirror_mode    = {idx_mirror_mode, 2'b00};
  localparam logic [9:0]  addr_uplink         = {idx_uplink, 2'b00};
  localparam logic [9:0]  addr_storm_low      = {idx_storm_low, 2'b00};
  localparam logic [9:0]  addr_flush_freeze   = {idx_flush_freeze, 2'b00};

  localparam int          bit_mirror_both     = 0;
  localparam int          bit_backpressure    = 7;
  localparam int          bit_half_duplex     = 6;
  localparam int          bit_flow_ctrl       = 5;
  localparam int          bit_slow_speed      = 4;
  localparam int          bit_null_vid_repl   = 3;
  localparam int          bit_flush           = 7;
  localparam int          bit_freeze          = 6;

  localparam logic        rst_mirror_both     = 1'b0;
  localparam logic [7:0]  rst_uplink          = 8'h00;
  localparam logic [7:0]  rst_storm_low       = 8'h4a;
  localparam logic [7:0]  rst_flush_freeze    = 8'h00;

  // flush takes this many cycles (one sweep of the counter memory)
  localparam logic [3:0]  flush_cycles        = 4'h8;

  // storm period, in ms, and derived cycle counts at 100 MHz
  localparam int          clk_mhz             = 100;
  localparam int          fast_period_ms      = 50;
  localparam int          slow_period_ms      = 500;
  localparam longint      fast_period_cyc     = longint'(fast_period_ms) * 1000 * clk_mhz;
  localparam longint      slow_period_cyc     = longint'(slow_period_ms) * 1000 * clk_mhz;

  typedef struct packed {
    logic        mirror_both;
    logic [7:0]  uplink;
    logic [7:0]  storm_low;
    logic [7:0]  flush_freeze;
    logic [3:0]  flush_cnt;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } regs_s;

  typedef struct packed {
    logic        backpressure;
    logic        half_duplex;
    logic        flow_ctrl;
    logic        slow_speed;
    logic        null_vid_repl;
    logic        mirror_both;
  } uplink_cfg_s;
endpackage

// >>> switch_global_control.sv
// global control 4..6: apb registers, mirror combine, storm budget, counter flush/freeze
`timescale 1ns/1ps
module switch_global_control #(
  parameter longint fast_period = global_ctl_pkg::fast_period_cyc,
  parameter longint slow_period = global_ctl_pkg::slow_period_cyc
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        mirror_src_match,
  input  wire logic                        mirror_dst_match,
  output logic                             mirror_hit,
  output global_ctl_pkg::uplink_cfg_s      uplink_cfg,
  input  wire logic [4:0]                  port_fast,
  input  wire logic [4:0]                  storm_block,
  input  wire logic [4:0]                  storm_pkt_start,
  output logic      [4:0]                  storm_drop,
  output logic      [4:0]                  counter_clear,
  output logic      [4:0]                  counter_hold,
  output logic      [10:0]                 storm_budget
);
  import global_ctl_pkg::*;

  typedef struct packed {
    regs_s        r;
    logic         mirror_hit;
    uplink_cfg_s  cfg;
    logic [4:0]   clear;
    logic [4:0]   hold;
    logic [10:0]  budget;
    logic [4:0]   drop;
  } state_s;

  state_s st;
  state_s next_st;
  logic [31:0] per_cnt [5];
  logic [31:0] next_per_cnt [5];
  logic [10:0] used [5];
  logic [10:0] next_used [5];
  logic [4:0]  over;
  logic [4:0]  next_over;

  function automatic logic [31:0] period_of(input logic fast);
    period_of = fast ? 32'(fast_period) : 32'(slow_period);
  endfunction

  logic wr_access;
  logic [9:0] waddr;
  assign wr_access = psel & penable & pwrite;
  assign waddr     = paddr[11:2];

  always_comb begin
    next_st = st;
    next_st.r.pready  = psel & ~penable;
    next_st.r.pslverr = 1'b0;
    // flush runs for a fixed sweep then the bit drops by itself
    if (st.r.flush_freeze[bit_flush]) begin
      if (st.r.flush_cnt == flush_cycles - 4'h1) begin
        next_st.r.flush_freeze[bit_flush] = 1'b0;
        next_st.r.flush_cnt = 4'h0;
      end else begin
        next_st.r.flush_cnt = st.r.flush_cnt + 4'h1;
      end
    end
    if (psel & ~penable) begin
      next_st.r.prdata = 32'h0;
      case (paddr[11:2])
        {2'b00, idx_mirror_mode}:  next_st.r.prdata = {31'h0, st.r.mirror_both};
        {2'b00, idx_uplink}:       next_st.r.prdata = {24'h0, st.r.uplink};
        {2'b00, idx_storm_low}:    next_st.r.prdata = {24'h0, st.r.storm_low};
        {2'b00, idx_flush_freeze}: next_st.r.prdata = {24'h0, st.r.flush_freeze & 8'hdf};
        default:                next_st.r.pslverr = 1'b1;
      endcase
    end
    if (st.r.pready & psel & penable) begin
      if (st.r.pslverr) next_st.r.pslverr = 1'b0;
      if (wr_access & ~st.r.pslverr) begin
        case (waddr)
          {2'b00, idx_mirror_mode}:  next_st.r.mirror_both = pwdata[bit_mirror_both];
          {2'b00, idx_uplink}:       next_st.r.uplink = pwdata[7:0];
          {2'b00, idx_storm_low}:    next_st.r.storm_low = pwdata[7:0];
          {2'b00, idx_flush_freeze}: begin
            next_st.r.flush_freeze = {pwdata[7:6] | {st.r.flush_freeze[bit_flush], 1'b0},
                                      1'b0, pwdata[4:0]};
            if (~st.r.flush_freeze[bit_flush]) next_st.r.flush_cnt = 4'h0;
          end
          default: ;
        endcase
      end
    end
    next_st.mirror_hit = st.r.mirror_both ? (mirror_src_match & mirror_dst_match)
                                          : (mirror_src_match | mirror_dst_match);
    next_st.cfg.backpressure  = st.r.uplink[bit_backpressure];
    next_st.cfg.half_duplex   = st.r.uplink[bit_half_duplex];
    next_st.cfg.flow_ctrl     = st.r.uplink[bit_flow_ctrl];
    next_st.cfg.slow_speed    = st.r.uplink[bit_slow_speed];
    next_st.cfg.null_vid_repl = st.r.uplink[bit_null_vid_repl];
    next_st.cfg.mirror_both   = st.r.mirror_both;
    next_st.budget = {st.r.uplink[2:0], st.r.storm_low};
    // per-port enables gate flush and freeze
    next_st.clear = st.r.flush_freeze[bit_flush]  ? st.r.flush_freeze[4:0] : 5'h0;
    next_st.hold  = st.r.flush_freeze[bit_freeze] ? st.r.flush_freeze[4:0]
                                                  : 5'h0;
    next_st.drop  = over;
  end

  // storm budget accounting per port
  always_comb begin
    for (int p = 0; p < 5; p++) begin
      next_per_cnt[p] = per_cnt[p] + 32'h1;
      next_used[p]    = used[p];
      next_over[p]    = over[p];
      if (per_cnt[p] >= period_of(port_fast[p]) - 32'h1) begin
        next_per_cnt[p] = 32'h0;
        next_used[p]    = 11'h0;
        next_over[p]    = 1'b0;
      end else begin
        if (storm_block[p] & (used[p] != 11'h7ff)) next_used[p] = used[p] + 11'h1;
        if (storm_pkt_start[p] & (used[p] >= st.budget)) next_over[p] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.r.mirror_both  <= rst_mirror_both;
      st.r.uplink       <= rst_uplink;
      st.r.storm_low    <= rst_storm_low;
      st.r.flush_freeze <= rst_flush_freeze;
      st.budget         <= {rst_uplink[2:0], rst_storm_low};
      over <= 5'h0;
      for (int p = 0; p < 5; p++) begin
        per_cnt[p] <= 32'h0;
        used[p]    <= 11'h0;
      end
    end else begin
      st   <= next_st;
      over <= next_over;
      for (int p = 0; p < 5; p++) begin
        per_cnt[p] <= next_per_cnt[p];
        used[p]    <= next_used[p];
      end
    end
  end

  assign prdata        = st.r.prdata;
  assign pready        = st.r.pready;
  assign pslverr       = st.r.pslverr;
  assign mirror_hit    = st.mirror_hit;
  assign uplink_cfg    = st.cfg;
  assign counter_clear = st.clear;
  assign counter_hold  = st.hold;
  assign storm_budget  = st.budget;
  assign storm_drop    = st.drop;

  property p_mirror;
    @(posedge pclk) disable iff (!presetn)
      ##1 mirror_hit == ($past(st.r.mirror_both) ? $past(mirror_src_match & mirror_dst_match)
                                                 : $past(mirror_src_match | mirror_dst_match));
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror combine wrong");

  property p_bp;
    @(posedge pclk) disable iff (!presetn)
      ##1 uplink_cfg.backpressure == $past(st.r.uplink[7]);
  endproperty
  a_bp: assert property (p_bp) else $error("back pressure mismatch");

  property p_duplex;
    @(posedge pclk) disable iff (!presetn)
      ##1 uplink_cfg.half_duplex == $past(st.r.uplink[6]);
  endproperty
  a_duplex: assert property (p_duplex) else $error("duplex mismatch");

  property p_speed;
    @(posedge pclk) disable iff (!presetn)
      ##1 (uplink_cfg.slow_speed == $past(st.r.uplink[4])) &&
          (uplink_cfg.flow_ctrl == $past(st.r.uplink[5]));
  endproperty
  a_speed: assert property (p_speed) else $error("speed or flow mismatch");

  property p_vid;
    @(posedge pclk) disable iff (!presetn)
      ##1 uplink_cfg.null_vid_repl == $past(st.r.uplink[3]);
  endproperty
  a_vid: assert property (p_vid) else $error("null id replace mismatch");

  property p_budget;
    @(posedge pclk) disable iff (!presetn)
      ##1 storm_budget == $past({st.r.uplink[2:0], st.r.storm_low});
  endproperty
  a_budget: assert property (p_budget) else $error("budget mismatch");

  sequence s_flush_set;
    $rose(st.r.flush_freeze[7]);
  endsequence
  property p_flush;
    @(posedge pclk) disable iff (!presetn)
      s_flush_set |-> ##[1:10] !st.r.flush_freeze[7];
  endproperty
  a_flush: assert property (p_flush) else $error("flush did not self clear");

  property p_freeze;
    @(posedge pclk) disable iff (!presetn)
      ##1 counter_hold == ($past(st.r.flush_freeze[6]) ? $past(st.r.flush_freeze[4:0]) : 5'h0);
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze gating wrong");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      (counter_clear & ~$past(st.r.flush_freeze[4:0])) == 5'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("disabled port flushed");

  property p_reset_values;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> (storm_budget == {rst_uplink[2:0], rst_storm_low}) &&
                         (uplink_cfg == '0);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  property p_combine_reset;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> !st.r.mirror_both;
  endproperty
  a_combine_reset: assert property (p_combine_reset) else $error("combine not reset");

  sequence s_setup;
    psel && !penable;
  endsequence
  property p_answer;
    @(posedge pclk) disable iff (!presetn)
      s_setup |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("setup not answered next cycle");

  property p_ready_once;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready stood too long");

  property p_err_with_ready;
    @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");

  property p_clear_en;
    @(posedge pclk) disable iff (!presetn)
      st.r.flush_freeze[bit_flush] |=> counter_clear == $past(st.r.flush_freeze[4:0]);
  endproperty
  a_clear_en: assert property (p_clear_en) else $error("flush enables not applied");

  property p_flush_sweep;
    @(posedge pclk) disable iff (!presetn)
      s_flush_set |-> st.r.flush_freeze[bit_flush] [*8];
  endproperty
  a_flush_sweep: assert property (p_flush_sweep) else $error("flush ended early");

  property p_drop_cause;
    @(posedge pclk) disable iff (!presetn)
      (storm_drop & ~$past(storm_drop) & ~$past(storm_pkt_start, 2)) == 5'h0;
  endproperty
  a_drop_cause: assert property (p_drop_cause) else $error("drop without start");

  property p_period_wrap;
    @(posedge pclk) disable iff (!presetn)
      (per_cnt[0] >= period_of(port_fast[0]) - 32'h1) |=>
        (per_cnt[0] == 32'h0) && !over[0];
  endproperty
  a_period_wrap: assert property (p_period_wrap) else $error("period did not wrap");

  sequence s_uplink_write;
    psel && penable && pwrite && pready && !pslverr && (paddr[11:2] == {2'b00, idx_uplink});
  endsequence
  property p_uplink_write;
    @(posedge pclk) disable iff (!presetn)
      s_uplink_write |=> st.r.uplink == $past(pwdata[7:0]);
  endproperty
  a_uplink_write: assert property (p_uplink_write) else $error("uplink write lost");
endmodule

// >>> testbench.sv
// self-checking bench for the global control 4..6 register block
`timescale 1ns/1ps
module testbench;
  import global_ctl_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, err, src = 0, dst = 0, mirror_hit;
  uplink_cfg_s uplink_cfg;
  logic [4:0]  port_fast = 5'h1f, storm_block = '0, storm_pkt_start = '0;
  logic [4:0]  storm_drop, counter_clear, counter_hold, en;
  logic [10:0] storm_budget;
  logic [7:0]  v;
  localparam int sim_period = 100;
  int          failures = 0, cmp_count = 0, cyc = 0, n, ph = 0;
  logic [31:0] rng = 32'd36519;

  switch_global_control #(.fast_period(sim_period), .slow_period(10 * sim_period)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mirror_src_match(src), .mirror_dst_match(dst), .mirror_hit(mirror_hit),
    .uplink_cfg(uplink_cfg), .port_fast(port_fast), .storm_block(storm_block),
    .storm_pkt_start(storm_pkt_start), .storm_drop(storm_drop),
    .counter_clear(counter_clear), .counter_hold(counter_hold), .storm_budget(storm_budget));

  always #5 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc++;
    // mirror of the fast storm period counter, used to keep strobes off its wrap edge
    if (presetn) ph <= (ph == sim_period - 1) ? 0 : ph + 1;
    if (cyc > 20000) begin
      failures++;
      wrap_up();
    end
  end

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  function automatic uplink_cfg_s cfg_exp(input logic [7:0] u, input logic mb);
    return '{u[7], u[6], u[5], u[4], u[3], mb};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic settle();
    @(posedge pclk);
  endtask

  // one apb transfer; request held until pready is sampled high at an edge
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, a};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    settle();
  endtask

  task automatic pulse(input logic blk, input logic [4:0] m);
    // a strobe on the period wrap edge is ignored by the design
    if (ph == sim_period - 2) settle();
    if (blk) storm_block <= m;
    else storm_pkt_start <= m;
    settle();
    storm_block     <= '0;
    storm_pkt_start <= '0;
    settle();
    settle();
  endtask

  // from a standing drop: wait for the period end, strike again, count to the next end
  task automatic probe(output int cnt);
    for (int r = 0; r < 2; r++) begin
      cnt = 0;
      while (storm_drop[0] === 1'b1 && cnt < 2000) begin
        settle();
        cnt++;
      end
      if (r == 0) pulse(0, 5'h01);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    check("budget_rst", 32'(storm_budget), 32'h04a);
    check("cfg_rst", 32'(uplink_cfg), 32'h0);
    apb(0, addr_mirror_mode, 0); check("mirror_rst", rd, 32'h0);
    apb(0, addr_uplink, 0);      check("uplink_rst", rd, 32'h0);
    apb(0, addr_storm_low, 0);   check("storm_rst", rd, 32'h4a);
    apb(0, addr_flush_freeze, 0); check("ff_rst", rd, 32'h0);
    apb(1, 10'h100, 32'hff);     check("bad_wr_err", 32'(err), 32'h1);
    apb(0, 10'h100, 0);          check("bad_rd", {rd[30:0], err}, 32'h1);
    apb(0, addr_uplink, 0);      check("bad_wr_ignored", rd, 32'h0);
    for (int mb = 0; mb < 2; mb++) begin
      apb(1, addr_mirror_mode, 32'(mb));
      for (int i = 0; i < 4; i++) begin
        src <= i[1];
        dst <= i[0];
        settle();
        settle();
        check("mirror_hit", 32'(mirror_hit), 32'(mb ? (i == 3) : (i != 0)));
      end
    end
    apb(1, addr_mirror_mode, 0);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hff : 8'(xs());
      apb(1, addr_uplink, 32'(v));
      apb(1, addr_storm_low, 32'(~v));
      settle();
      check("cfg", 32'(uplink_cfg), 32'(cfg_exp(v, 1'b0)));
      check("budget", 32'(storm_budget), {21'h0, v[2:0], ~v});
      apb(0, addr_uplink, 0); check("uplink_rd", rd, 32'(v));
    end
    for (int i = 0; i < 4; i++) begin
      en = (i == 0) ? 5'h00 : 5'(xs());
      apb(1, addr_flush_freeze, {24'h0, 3'b100, en});
      settle();
      check("clear_on", 32'(counter_clear), 32'(en));
      repeat (12) settle();
      check("clear_off", 32'(counter_clear), 32'h0);
      apb(0, addr_flush_freeze, 0); check("flush_sc", rd, 32'(en));
      apb(1, addr_flush_freeze, {24'h0, 3'b011, en});
      settle();
      check("hold", 32'(counter_hold), 32'(en));
      apb(0, addr_flush_freeze, 0); check("ff_rd", rd, {24'h0, 3'b010, en});
    end
    apb(1, addr_flush_freeze, 0);
    settle();
    check("hold_off", 32'(counter_hold), 32'h0);
    apb(1, addr_uplink, 0);
    apb(1, addr_storm_low, 0);
    pulse(0, 5'h01);
    check("drop_zero_budget", 32'(storm_drop), 32'h01);
    probe(n);
    check("fast_period", 32'(n >= 90 && n <= 100), 32'h1);
    apb(1, addr_storm_low, 3);
    pulse(1, 5'h03);
    pulse(1, 5'h01);
    pulse(0, 5'h03);
    check("under_budget", 32'(storm_drop), 32'h0);
    pulse(1, 5'h01);
    pulse(0, 5'h03);
    check("over_budget", 32'(storm_drop), 32'h01);
    port_fast <= 5'h1e;
    apb(1, addr_storm_low, 0);
    probe(n);
    check("slow_period", 32'(n >= 990 && n <= 1000), 32'h1);
    wrap_up();
  end
endmodule
